// ==== shared/dcp_params.svh ====
/*
 Constants of the two-wire command port: address, register offsets, field
 positions and reset values. Assumes inclusion by bare name from design files.
*/
`ifndef DCP_PARAMS_SVH
`define DCP_PARAMS_SVH

// ----------------------------------------------------------------------------
// Addressing
// ----------------------------------------------------------------------------
`define DCP_ADDR_PREFIX 4'h9
`define DCP_BCAST_ADDR 7'h47
`define DCP_STRAP_GND 3'h0
`define DCP_STRAP_VDD 3'h1
`define DCP_STRAP_SDA 3'h2
`define DCP_STRAP_SCL 3'h3

// ----------------------------------------------------------------------------
// Register offsets, as carried in the low nibble of the command byte
// ----------------------------------------------------------------------------
`define DCP_OFS_SYNC 4'h2
`define DCP_OFS_PWDN 4'h3
`define DCP_OFS_GAIN 4'h4
`define DCP_OFS_TRIG 4'h5
`define DCP_OFS_CODE 4'h8

// ----------------------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------------------
`define DCP_SYNC_EN_BIT 0
`define DCP_REF_PD_BIT 8
`define DCP_OUT_PD_BIT 0
`define DCP_REF_DIV_BIT 8
`define DCP_GAIN_BIT 0
`define DCP_LOAD_BIT 4
`define DCP_SOFT_RESET_CODE 4'hA
`define DCP_TRIG_READ_MASK 16'hFFF0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define DCP_RST_SYNC 16'h0000
`define DCP_RST_PWDN 16'h0000
`define DCP_RST_GAIN 16'h0001
`define DCP_RST_TRIG 16'h0000
`define DCP_RST_CODE 16'h0000

`endif

// ==== shared/dcp_pkg.sv ====
/*
 Types of the two-wire command port.
 Assumes nothing of its surroundings.
*/
package dcp_pkg;

	// ------------------------------------------------------------------------
	// Frame states, Gray coded along the write path
	// ------------------------------------------------------------------------
	typedef enum logic [2:0] {
		DCP_IDLE = 3'h0,
		DCP_ADDR = 3'h1,
		DCP_CMD = 3'h3,
		DCP_HIGH = 3'h2,
		DCP_LOW = 3'h6,
		DCP_TXH = 3'h7,
		DCP_TXL = 3'h5,
		DCP_IGNORE = 3'h4
	} dcp_state_t;

endpackage

// ==== src/dcp_i2c_port.sv ====
/*
 Two-wire target command port of a single-channel output converter: address
 match with strap decode, command and data bytes, five registers, readback.
 Assumes SCL and SDA are oversampled by MCLK far above the bus bit rate, and
 that an external open-drain pad resolves SDA from SDA_OUT and SDA_OE.
*/
`timescale 1ns/10ps
`include "dcp_params.svh"

module dcp_i2c_port import dcp_pkg::*; #(
	parameter int RESOLUTION = 16,
	parameter logic [15:0] CODE_RESET = `DCP_RST_CODE
)(
	// Clock and reset.
	input wire logic MCLK,
	input wire logic RESET_N,
	// Two-wire bus pins.
	input wire logic SCL,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	// Address strap, tied to ground, supply, SDA or SCL.
	input wire logic ADDRESS_STRAP_PIN,
	// Analog control outputs.
	output logic [15:0] OUTPUT_CODE,
	output logic REFERENCE_POWER_DOWN,
	output logic OUTPUT_POWER_DOWN,
	output logic REFERENCE_HALF,
	output logic BUFFER_GAIN_TWO
);
	localparam logic [15:0] CODE_MASK = 16'(32'hFFFF << (16 - RESOLUTION));

	logic rst_meta, rst_n;
	logic scl_f, sda_f, strap_f, scl_d, sda_d;
	dcp_state_t state, next_state;
	logic [3:0] bit_cnt;
	logic [7:0] shreg, tx_byte, hi_byte;
	logic rw_q, m_ack, cmd_seen, sda_low;
	logic seen_hi, seen_lo, ne_sda;
	logic [3:0] ptr, last_wr;
	logic [15:0] sync_reg, pwdn_reg, gain_reg, trig_reg, code_buf;

	// ------------------------------------------------------------------------
	// Reset release and pin synchronisers
	// ------------------------------------------------------------------------
	// Reset asserts at once and releases through two flops.
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	dcp_sync #(.WIDTH(3), .INIT(3'h7)) u_sync (
		.clk(MCLK),
		.rst_n(rst_n),
		.din({SCL, SDA_IN, ADDRESS_STRAP_PIN}),
		.dout({scl_f, sda_f, strap_f})
	);

	// ------------------------------------------------------------------------
	// Bus events
	// ------------------------------------------------------------------------
	// Edges and conditions are taken from the filtered levels only.
	wire scl_rise = scl_f & ~scl_d;
	wire scl_fall = ~scl_f & scl_d;
	wire start_ev = scl_f & scl_d & sda_d & ~sda_f;
	wire stop_ev = scl_f & scl_d & ~sda_d & sda_f;
	wire byte_end = scl_fall & (bit_cnt == 4'h8);
	wire ack_end = scl_fall & (bit_cnt == 4'h9);
	wire in_tx = (state == DCP_TXH) || (state == DCP_TXL);

	// Address and command decode.
	wire [2:0] strap_code = !seen_hi ? `DCP_STRAP_GND : !seen_lo ? `DCP_STRAP_VDD :
		!ne_sda ? `DCP_STRAP_SDA : `DCP_STRAP_SCL;
	wire [6:0] addr7 = shreg[7:1];
	wire gen_hit = addr7 == {`DCP_ADDR_PREFIX, strap_code};
	wire bc_hit = (addr7 == `DCP_BCAST_ADDR) && !shreg[0];
	wire addr_hit = gen_hit | bc_hit;
	wire [3:0] nib = shreg[3:0];
	wire cmd_ok = (shreg[7:4] == 4'h0) && (nib == `DCP_OFS_SYNC || nib == `DCP_OFS_PWDN ||
		nib == `DCP_OFS_GAIN || nib == `DCP_OFS_TRIG || nib == `DCP_OFS_CODE);

	// Write strobe at the falling edge closing the low byte acknowledge.
	wire wr_pulse = ack_end && (state == DCP_LOW);
	wire [15:0] wdata = {hi_byte, shreg};
	wire soft_rst = wr_pulse && (ptr == `DCP_OFS_TRIG) &&
		(shreg[3:0] == `DCP_SOFT_RESET_CODE);
	wire load_now = wr_pulse && (ptr == `DCP_OFS_TRIG) && wdata[`DCP_LOAD_BIT] &&
		sync_reg[`DCP_SYNC_EN_BIT];
	wire code_now = wr_pulse && (ptr == `DCP_OFS_CODE) && !sync_reg[`DCP_SYNC_EN_BIT];

	// Read source: commanded register, or the last one written.
	wire [3:0] rd_sel = cmd_seen ? ptr : last_wr;
	wire [15:0] rd_word = (rd_sel == `DCP_OFS_SYNC) ? sync_reg :
		(rd_sel == `DCP_OFS_PWDN) ? pwdn_reg :
		(rd_sel == `DCP_OFS_GAIN) ? gain_reg :
		(rd_sel == `DCP_OFS_TRIG) ? (trig_reg & `DCP_TRIG_READ_MASK) :
		code_buf;

	// ------------------------------------------------------------------------
	// Frame sequencing
	// ------------------------------------------------------------------------
	// Next state; an unmatched address or a bad command parks the frame.
	always_comb begin
		next_state = state;
		if (stop_ev) begin
			next_state = DCP_IDLE;
		end else if (start_ev) begin
			next_state = DCP_ADDR;
		end else if (byte_end && state == DCP_ADDR && !addr_hit) begin
			next_state = DCP_IGNORE;
		end else if (byte_end && state == DCP_CMD && !cmd_ok) begin
			next_state = DCP_IGNORE;
		end else if (ack_end) begin
			unique case (state)
				DCP_ADDR: next_state = rw_q ? DCP_TXH : DCP_CMD;
				DCP_CMD: next_state = DCP_HIGH;
				DCP_HIGH: next_state = DCP_LOW;
				DCP_LOW: next_state = DCP_HIGH;
				DCP_TXH: next_state = m_ack ? DCP_TXL : DCP_IGNORE;
				DCP_TXL: next_state = DCP_IGNORE;
				DCP_IDLE, DCP_IGNORE: next_state = state;
			endcase
		end
	end

	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			state <= DCP_IDLE;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			sda_low <= 1'b0;
		end else begin
			state <= next_state;
			scl_d <= scl_f;
			sda_d <= sda_f;
			sda_low <= 1'b0;
		end
	end

	// Bit counter and receive shifter; rising edges 1..8 carry data.
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			rw_q <= 1'b0;
			m_ack <= 1'b0;
		end else if (start_ev || ack_end) begin
			bit_cnt <= 4'h0;
		end else if (scl_rise && bit_cnt != 4'h9) begin
			bit_cnt <= bit_cnt + 4'h1;
			shreg <= (bit_cnt < 4'h8) ? {shreg[6:0], sda_f} : shreg;
			m_ack <= (bit_cnt == 4'h8) ? !sda_f : m_ack;
			rw_q <= (bit_cnt == 4'h7 && state == DCP_ADDR) ? sda_f : rw_q;
		end
	end

	// Strap watch across the address byte, decoded and latched at its end.
	// Strap and SDA pass one synchroniser, u_sync, bit by bit and may differ for a cycle
	// around an SDA edge, so they are compared only while SCL stands high.
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			{seen_hi, seen_lo, ne_sda} <= 3'h0;
		end else if (start_ev) begin
			{seen_hi, seen_lo, ne_sda} <= 3'h0;
		end else if (state == DCP_ADDR && bit_cnt < 4'h8) begin
			seen_hi <= seen_hi | strap_f;
			seen_lo <= seen_lo | !strap_f;
			ne_sda <= ne_sda | (scl_f && scl_d && (strap_f != sda_f));
		end
	end

	// SDA drive: acknowledge after received bytes, data bits while sending.
	// Driving only on falling SCL keeps SDA stable through every high phase.
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			SDA_OE <= 1'b0;
			tx_byte <= 8'h00;
		end else if (start_ev || stop_ev) begin
			SDA_OE <= 1'b0;
		end else if (byte_end) begin
			SDA_OE <= !in_tx && (next_state != DCP_IGNORE) && (state != DCP_IDLE);
		end else if (ack_end) begin
			tx_byte <= (next_state == DCP_TXH) ? rd_word[15:8] : rd_word[7:0];
			SDA_OE <= (next_state == DCP_TXH) ? !rd_word[15] :
				(next_state == DCP_TXL) ? !rd_word[7] : 1'b0;
		end else if (scl_fall && in_tx && bit_cnt < 4'h8 && bit_cnt != 4'h0) begin
			tx_byte <= {tx_byte[6:0], 1'b0};
			SDA_OE <= !tx_byte[6];
		end
	end

	assign SDA_OUT = sda_low;

	// ------------------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------------------
	// Command pointer and the readback source bookkeeping.
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			ptr <= `DCP_OFS_CODE;
			last_wr <= `DCP_OFS_CODE;
			cmd_seen <= 1'b0;
			hi_byte <= 8'h00;
		end else begin
			cmd_seen <= stop_ev ? 1'b0 : (ack_end && state == DCP_CMD) ? 1'b1 : cmd_seen;
			ptr <= (ack_end && state == DCP_CMD) ? shreg[3:0] : ptr;
			last_wr <= wr_pulse ? ptr : last_wr;
			hi_byte <= (ack_end && state == DCP_HIGH) ? shreg : hi_byte;
		end
	end

	// Configuration registers; the reset code restores every default.
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			sync_reg <= `DCP_RST_SYNC;
			pwdn_reg <= `DCP_RST_PWDN;
			gain_reg <= `DCP_RST_GAIN;
			trig_reg <= `DCP_RST_TRIG;
		end else if (soft_rst) begin
			sync_reg <= `DCP_RST_SYNC;
			pwdn_reg <= `DCP_RST_PWDN;
			gain_reg <= `DCP_RST_GAIN;
			trig_reg <= `DCP_RST_TRIG;
		end else if (wr_pulse) begin
			sync_reg <= (ptr == `DCP_OFS_SYNC) ? wdata : sync_reg;
			pwdn_reg <= (ptr == `DCP_OFS_PWDN) ? wdata : pwdn_reg;
			gain_reg <= (ptr == `DCP_OFS_GAIN) ? wdata : gain_reg;
			trig_reg <= (ptr == `DCP_OFS_TRIG) ? wdata : trig_reg;
		end
	end

	// Pending and active output code, left aligned to the resolution.
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			code_buf <= CODE_RESET & CODE_MASK;
			OUTPUT_CODE <= CODE_RESET & CODE_MASK;
		end else if (soft_rst) begin
			code_buf <= CODE_RESET & CODE_MASK;
			OUTPUT_CODE <= CODE_RESET & CODE_MASK;
		end else begin
			code_buf <= (wr_pulse && ptr == `DCP_OFS_CODE) ? (wdata & CODE_MASK) : code_buf;
			OUTPUT_CODE <= code_now ? (wdata & CODE_MASK) :
				load_now ? code_buf : OUTPUT_CODE;
		end
	end

	// Analog controls come straight from register bits.
	assign REFERENCE_POWER_DOWN = pwdn_reg[`DCP_REF_PD_BIT];
	assign OUTPUT_POWER_DOWN = pwdn_reg[`DCP_OUT_PD_BIT];
	assign REFERENCE_HALF = gain_reg[`DCP_REF_DIV_BIT];
	assign BUFFER_GAIN_TWO = gain_reg[`DCP_GAIN_BIT];

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking @(posedge MCLK); endclocking
	default disable iff (!rst_n);

	ignore_quiet_a: assert property (state == DCP_IGNORE |-> !SDA_OE)
		else $error("SDA driven in an ignored frame");
	bcast_read_a: assert property (byte_end && state == DCP_ADDR && addr7 == `DCP_BCAST_ADDR
		&& shreg[0] && !gen_hit |=> !SDA_OE)
		else $error("broadcast read acknowledged");
	addr_ack_a: assert property (byte_end && state == DCP_ADDR && gen_hit |=> SDA_OE
		&& state != DCP_IGNORE)
		else $error("matching address not acknowledged");
	code_async_a: assert property (code_now && !soft_rst |=>
		OUTPUT_CODE == ($past(wdata) & CODE_MASK))
		else $error("immediate code update missing");
	code_hold_a: assert property (!code_now && !load_now && !soft_rst |=> $stable(OUTPUT_CODE))
		else $error("output code moved without cause");
	load_code_a: assert property (load_now && !soft_rst |=> OUTPUT_CODE == $past(code_buf))
		else $error("load trigger did not move pending code");
	soft_reset_a: assert property (soft_rst |=> gain_reg == `DCP_RST_GAIN
		&& sync_reg == `DCP_RST_SYNC && pwdn_reg == `DCP_RST_PWDN)
		else $error("software reset left registers changed");
	write_only_low_a: assert property ($changed(gain_reg) |-> $past(state) == DCP_LOW)
		else $error("register changed outside low byte end");
	pwdn_map_a: assert property (wr_pulse && ptr == `DCP_OFS_PWDN && !soft_rst |=>
		OUTPUT_POWER_DOWN == $past(shreg[0]))
		else $error("power-down bit not applied");
	gain_map_a: assert property (wr_pulse && ptr == `DCP_OFS_GAIN |=>
		BUFFER_GAIN_TWO == $past(shreg[0]) && REFERENCE_HALF == $past(hi_byte[0]))
		else $error("gain bits not applied");
	trig_read_a: assert property (rd_sel == `DCP_OFS_TRIG |-> rd_word[3:0] == 4'h0)
		else $error("reset field visible on readback");

	write_cov: cover property (wr_pulse && ptr == `DCP_OFS_CODE);
	read_cov: cover property (ack_end && state == DCP_TXL);
	bcast_cov: cover property (byte_end && state == DCP_ADDR && bc_hit);
	soft_cov: cover property (soft_rst);
endmodule

// ==== src/dcp_sync.sv ====
/*
 Three-stage input synchroniser with agreement filter.
 Assumes asynchronous inputs and an active-low reset already in the clock domain.
*/
`timescale 1ns/10ps
module dcp_sync #(parameter int WIDTH = 1, parameter logic [WIDTH-1:0] INIT = '1)(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Raw and filtered levels.
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] ff1;
	logic [WIDTH-1:0] ff2;
	logic [WIDTH-1:0] ff3;
	logic [WIDTH-1:0] agree;

	// A bit moves only when the second and third stages agree, which hides
	// a single metastable resolution from the logic downstream.
	assign agree = ~(ff2 ^ ff3);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ff1 <= INIT;
			ff2 <= INIT;
			ff3 <= INIT;
			dout <= INIT;
		end else begin
			ff1 <= din;
			ff2 <= ff1;
			ff3 <= ff2;
			dout <= (agree & ff3) | (~agree & dout);
		end
	end
endmodule

// ==== verif/dcp_i2c_port_tb.sv ====
/*
 Self-checking bench of the two-wire command port driven by a master model.
 Assumes an open-drain SDA with pull-up and a 16-bit output resolution.
*/
`timescale 1ns/10ps
`include "dcp_params.svh"
module dcp_i2c_port_tb;
	// ------------------------------------------------------------------------
	// Wiring
	// ------------------------------------------------------------------------
	logic mclk, reset_n, strap, sda_out, sda_oe, scl, m_low, ref_pd, out_pd;
	logic ref_half, gain_two;
	logic [1:0] strap_sel;
	logic [15:0] code, got, mcode;
	logic [19:0] last_out;
	logic [15:0] bq[$];
	logic [19:0] oq[$];
	int err_count, tests_run, cycles;
	event bus_ev;
	// Open drain: anyone pulling wins, else the pull-up.
	wire sda = ((sda_oe && !sda_out) || m_low) ? 1'b0 : 1'b1;
	wire [19:0] out_word = {code, ref_pd, out_pd, ref_half, gain_two};

	dcp_i2c_port dut (.MCLK(mclk), .RESET_N(reset_n), .SCL(scl), .SDA_IN(sda),
		.SDA_OUT(sda_out), .SDA_OE(sda_oe), .ADDRESS_STRAP_PIN(strap),
		.OUTPUT_CODE(code), .REFERENCE_POWER_DOWN(ref_pd),
		.OUTPUT_POWER_DOWN(out_pd), .REFERENCE_HALF(ref_half),
		.BUFFER_GAIN_TWO(gain_two));
	dcp_master master (.scl(scl), .sda_low(m_low), .sda(sda));

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// Strap follows ground, supply, SDA or SCL, refreshed off the MCLK edge.
	always @(negedge mclk) begin
		strap <= (strap_sel == 2'h2) ? sda : (strap_sel == 2'h3) ? scl : strap_sel[0];
	end

	// ------------------------------------------------------------------------
	// Checking
	// ------------------------------------------------------------------------
	task automatic cmp_bus(input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED bus at %0t: expected %h got %h", $time, e, g);
		end
	endtask

	task automatic cmp_out(input logic [19:0] e, input logic [19:0] g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED out at %0t: expected %h got %h", $time, e, g);
		end
	endtask

	task automatic wrap_up;
		if (err_count == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Oldest note is taken whenever a bus result arrives.
	always @(bus_ev) cmp_bus(bq.pop_front(), got);

	// Any output change must match the oldest note; a change with none is wrong.
	always @(negedge mclk) begin
		if (reset_n && out_word !== last_out) begin
			cmp_out((oq.size() > 0) ? oq.pop_front() : last_out, out_word);
			last_out = out_word;
		end
	end

	// A hang is cut short well past the expected run length.
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 80000) begin
			err_count++;
			wrap_up();
		end
	end

	// ------------------------------------------------------------------------
	// Bus transfers
	// ------------------------------------------------------------------------
	task automatic send(input logic [7:0] b, input logic e);
		logic a;
		bq.push_back({15'h0, e});
		master.wr_byte(b, a);
		got = {15'h0, a};
		->bus_ev;
	endtask

	task automatic bad_byte(input logic [7:0] b);
		master.start();
		send(b, 1'b0);
		master.stop();
	endtask

	task automatic wr_reg(input logic [6:0] ad, input logic [3:0] ofs, input logic [15:0] v);
		master.start();
		send({ad, 1'b0}, 1'b1);
		send({4'h0, ofs}, 1'b1);
		send(v[15:8], 1'b1);
		send(v[7:0], 1'b1);
		master.stop();
	endtask

	// A negative offset asks for a direct read of the last written register.
	task automatic rd_reg(input logic [6:0] ad, input int ofs, input logic [15:0] e);
		logic [7:0] h, l;
		master.start();
		if (ofs >= 0) begin
			send({ad, 1'b0}, 1'b1);
			send({4'h0, 4'(ofs)}, 1'b1);
			master.start();
		end
		send({ad, 1'b1}, 1'b1);
		bq.push_back(e);
		master.rd_byte(1'b1, h);
		master.rd_byte(1'b0, l);
		got = {h, l};
		->bus_ev;
		master.stop();
	endtask

	// ------------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------------
	initial begin
		logic [6:0] ad;
		logic [15:0] val;
		reset_n = 1'b0;
		strap_sel = 2'h0;
		strap = 1'b0;
		cycles = 0;
		err_count = 0;
		tests_run = 0;
		mcode = 16'h0000;
		last_out = 20'h00001;
		ad = {`DCP_ADDR_PREFIX, `DCP_STRAP_GND};
		void'($urandom(32'h5BAE));
		repeat (10) @(negedge mclk);
		reset_n = 1'b1;
		repeat (20) @(negedge mclk);
		cmp_out(20'h00001, out_word);
		rd_reg(ad, -1, 16'h0000);
		// Every strap connection, with the neighbouring address refused.
		for (int s = 0; s < 4; s++) begin
			strap_sel = 2'(s);
			ad = {`DCP_ADDR_PREFIX, 3'(s)};
			val = mcode ^ (16'($urandom) | 16'h8000);
			mcode = val;
			bad_byte({ad ^ 7'h01, 1'b0});
			oq.push_back({val, 4'h1});
			wr_reg(ad, `DCP_OFS_CODE, val);
			rd_reg(ad, `DCP_OFS_CODE, val);
		end
		oq.push_back({mcode, 4'hD});
		wr_reg(`DCP_BCAST_ADDR, `DCP_OFS_PWDN, 16'h0101);
		bad_byte({`DCP_BCAST_ADDR, 1'b1});
		oq.push_back({mcode, 4'hE});
		wr_reg(ad, `DCP_OFS_GAIN, 16'h0100);
		rd_reg(ad, -1, 16'h0100);
		// Synchronous mode holds the code until the load bit.
		wr_reg(ad, `DCP_OFS_SYNC, 16'h0001);
		val = mcode ^ 16'h5A5A;
		mcode = val;
		wr_reg(ad, `DCP_OFS_CODE, val);
		rd_reg(ad, `DCP_OFS_CODE, val);
		oq.push_back({val, 4'hE});
		wr_reg(ad, `DCP_OFS_TRIG, 16'h0013);
		rd_reg(ad, `DCP_OFS_TRIG, 16'h0010);
		// Cut-short write, then an unknown command.
		master.start();
		send({ad, 1'b0}, 1'b1);
		send({4'h0, `DCP_OFS_CODE}, 1'b1);
		send(8'hFF, 1'b1);
		master.stop();
		master.start();
		send({ad, 1'b0}, 1'b1);
		send(8'h06, 1'b0);
		master.stop();
		// Software reset code brings every register back.
		oq.push_back(20'h00001);
		wr_reg(ad, `DCP_OFS_TRIG, 16'h000A);
		rd_reg(ad, `DCP_OFS_SYNC, 16'h0000);
		rd_reg(ad, `DCP_OFS_PWDN, 16'h0000);
		rd_reg(ad, `DCP_OFS_GAIN, 16'h0001);
		repeat (50) @(negedge mclk);
		cmp_bus(16'(bq.size() + oq.size()), 16'h0000);
		wrap_up();
	end
endmodule

// ==== verif/dcp_master.sv ====
/*
 Two-wire bus master model that drives SCL and pulls SDA low.
 Assumes SDA is resolved outside with a pull-up; SCL idles high between frames.
*/
`timescale 1ns/10ps
module dcp_master (
	// Bus pins.
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	logic lclk;

	// Own 80 ns link clock, offset so it never lines up with MCLK.
	initial begin
		lclk = 1'b0;
		scl = 1'b1;
		sda_low = 1'b0;
		#3;
		forever #40 lclk = ~lclk;
	end

	// One bit: SCL low for two link ticks, data moves mid-low, sampled mid-high.
	task automatic bit_io(input logic b, output logic r);
		@(posedge lclk) scl <= 1'b0;
		@(posedge lclk) sda_low <= ~b;
		@(posedge lclk) scl <= 1'b1;
		@(posedge lclk) r = sda;
	endtask

	// Start or repeated start; SDA is released before it falls under SCL high.
	task automatic start;
		@(posedge lclk) scl <= 1'b0;
		@(posedge lclk) sda_low <= 1'b0;
		@(posedge lclk) scl <= 1'b1;
		@(posedge lclk) sda_low <= 1'b1;
		@(posedge lclk);
	endtask

	// Stop; SCL then stands still high.
	task automatic stop;
		@(posedge lclk) scl <= 1'b0;
		@(posedge lclk) sda_low <= 1'b1;
		@(posedge lclk) scl <= 1'b1;
		@(posedge lclk) sda_low <= 1'b0;
		@(posedge lclk);
	endtask

	// Byte out, MSB first, returns whether the target acknowledged.
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask

	// Byte in; the master acks the high byte and nacks the last one.
	task automatic rd_byte(input logic m_ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(~m_ack, r);
	endtask
endmodule
